// ---- core/scsm_pkg.sv ----
// shared constants and types for the self-test clock and scan steering
package scsm_pkg;

   // serial access data register layout
   localparam int unsigned DR_W         = 16;
   localparam int unsigned DR_MODE_BIT  = 0;
   localparam int unsigned DR_RUN_BIT   = 1;
   localparam int unsigned DR_DONE_BIT  = 2;
   localparam int unsigned DR_PAT_LSB   = 8;
   localparam int unsigned DR_PAT_W     = 8;
   localparam logic [15:0] DR_RST       = 16'h0000;

   // self-test sequencer timing, in self-test clock periods or clk cycles
   localparam logic [7:0]  SHIFT_LEN    = 8'h20;
   localparam logic [7:0]  CAP_CYC      = 8'h04;
   localparam logic [7:0]  DEAD_CYC     = 8'h08;

   // controller end register map, byte addresses
   localparam logic [7:0]  A_CMD        = 8'h00;
   localparam logic [7:0]  A_WDATA      = 8'h04;
   localparam logic [7:0]  A_RDATA      = 8'h08;
   localparam logic [7:0]  A_STAT       = 8'h0c;
   localparam logic [7:0]  A_CCFG       = 8'h10;
   localparam int unsigned CMD_LEN_LSB  = 0;
   localparam int unsigned CMD_LEN_W    = 6;
   localparam int unsigned CMD_START    = 8;
   localparam int unsigned CMD_TLR      = 9;
   localparam int unsigned CMD_DEC      = 10;
   localparam int unsigned CMD_GATED    = 11;
   localparam int unsigned CCFG_W       = 4;
   localparam logic [31:0] CMD_RST      = 32'h0000_0000;
   localparam logic [3:0]  CCFG_RST     = 4'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SHIFT = 3'b001,
      ST_PRE   = 3'b010,
      ST_CAP   = 3'b011,
      ST_POST  = 3'b100
   } scsm_st_t;

   typedef enum logic [1:0] {
      TS_IDLE  = 2'b00,
      TS_CAP   = 2'b01,
      TS_SHIFT = 2'b10,
      TS_UPD   = 2'b11
   } scsm_tap_st_t;

endpackage : scsm_pkg

// ---- core/scsm_if.sv ----
// link between the steering device and the clock controller / tap end
`timescale 1ns/10ps
interface scsm_if;
   logic tck;
   logic tap_si;
   logic tap_so;
   logic cap_dr;
   logic sh_dr;
   logic upd_dr;
   logic tlr;
   logic instr_dec;
   logic cc_shift_clk;
   logic cc_shift_clk_en;
   logic cc_scan_en;
   logic cc_clkout;

   modport dev (
      input  tck,
      input  tap_si,
      output tap_so,
      input  cap_dr,
      input  sh_dr,
      input  upd_dr,
      input  tlr,
      input  instr_dec,
      output cc_shift_clk,
      output cc_shift_clk_en,
      output cc_scan_en,
      input  cc_clkout
   );

   modport ctl (
      output tck,
      output tap_si,
      input  tap_so,
      output cap_dr,
      output sh_dr,
      output upd_dr,
      output tlr,
      output instr_dec,
      input  cc_shift_clk,
      input  cc_shift_clk_en,
      input  cc_scan_en,
      output cc_clkout
   );
endinterface : scsm_if

// ---- core/scsm_dev.sv ----
// steering device: self-test sequencer, clock and scan-enable muxes, access network
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
module scsm_dev
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cmp_clk_in,
   input  wire logic top_shift_clk,
   input  wire logic atpg_scan_en,
   input  wire logic atpg_shift_clk_en,
   input  wire logic cmp_update_in,
   input  wire logic cmp_bypass_in,
   input  wire logic cmp_lowpow_in,
   output wire logic cmp_update,
   output wire logic cmp_bypass,
   output wire logic cmp_lowpow,
   output wire logic cmp_clk,
   output wire logic chain_clk,
   output wire logic sig_clk,
   output wire logic st_scan_en,
   output wire logic st_mode,
   output wire logic st_busy,
   scsm_if.dev       lnk
);

   // period counter end test, shared by every phase
   function automatic logic cnt_last(input logic [7:0] cnt, input logic [7:0] lim);
      cnt_last = (cnt == (lim - 8'h01));
   endfunction : cnt_last

   logic                  tck_q_ff;
   logic [15:0]           dr_ff;
   logic                  sib_sh_ff;
   logic                  sib_open_ff;
   logic                  pipe_ff;
   logic                  mode_ff;
   logic                  done_ff;
   scsm_pkg::scsm_st_t    st_ff;
   scsm_pkg::scsm_st_t    nxt_st;
   logic [7:0]            cnt_ff;
   logic [7:0]            nxt_cnt;
   logic [7:0]            pat_ff;
   logic [7:0]            nxt_pat;
   logic                  st_clk_ff;
   logic                  scan_en_ff;
   logic                  cap_en_ff;

   // access strobes are sampled on rising edges of the tap clock
   wire        tck_rise  = lnk.tck & ~tck_q_ff;
   wire        tap_go    = tck_rise & lnk.instr_dec & ~lnk.tlr;
   wire        tap_rst   = tck_rise & lnk.tlr;
   wire        do_cap    = tap_go & lnk.cap_dr;
   wire        do_shift  = tap_go & ~lnk.cap_dr & lnk.sh_dr;
   wire        do_upd    = tap_go & ~lnk.cap_dr & ~lnk.sh_dr & lnk.upd_dr;
   wire        upd_seg   = do_upd & sib_open_ff;
   wire        idle      = (st_ff == scsm_pkg::ST_IDLE);
   wire [7:0]  pat_req   = dr_ff[scsm_pkg::DR_PAT_LSB +: scsm_pkg::DR_PAT_W];
   wire        start     = upd_seg & idle & dr_ff[scsm_pkg::DR_RUN_BIT]
                           & dr_ff[scsm_pkg::DR_MODE_BIT] & (pat_req != 8'h00);
   wire [15:0] stat_w    = {pat_ff, 5'h00, done_ff, ~idle, mode_ff};
   wire        seg_out   = sib_open_ff ? dr_ff[0] : lnk.tap_si;

   // segment sits between scan-in and the insertion bit
   wire [15:0] nxt_dr    = do_cap   ? stat_w :
                           do_shift ? {lnk.tap_si, dr_ff[15:1]} : dr_ff;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tck_q_ff    <= 1'b0;
         dr_ff       <= scsm_pkg::DR_RST;
         sib_sh_ff   <= 1'b0;
         sib_open_ff <= 1'b0;
         pipe_ff     <= 1'b0;
      end
      else if (tap_rst)
      begin
         tck_q_ff    <= lnk.tck;
         dr_ff       <= scsm_pkg::DR_RST;
         sib_sh_ff   <= 1'b0;
         sib_open_ff <= 1'b0;
         pipe_ff     <= 1'b0;
      end
      else
      begin
         tck_q_ff <= lnk.tck;
         if (sib_open_ff)
         begin
            dr_ff <= nxt_dr;
         end
         if (do_cap)
         begin
            sib_sh_ff <= sib_open_ff;
         end
         if (do_shift)
         begin
            sib_sh_ff <= seg_out;
            // retiming stage for a tap that re-registers its serial output
            pipe_ff   <= sib_sh_ff;
         end
         if (do_upd)
         begin
            sib_open_ff <= sib_sh_ff;
         end
      end
   end

   assign lnk.tap_so = pipe_ff;

   // mode moves only while the sequencer is stopped, so no shift is cut short
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mode_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         if (upd_seg && idle)
         begin
            mode_ff <= dr_ff[scsm_pkg::DR_MODE_BIT];
         end
         // finishing wins over the clear by a new start
         if (st_ff == scsm_pkg::ST_POST && cnt_last(cnt_ff, scsm_pkg::DEAD_CYC)
             && pat_ff == 8'h00)
         begin
            done_ff <= 1'b1;
         end
         else if (start)
         begin
            done_ff <= 1'b0;
         end
      end
   end

   // self-test sequencer: shift, dead cycles, capture, dead cycles
   always_comb
   begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff;
      nxt_pat = pat_ff;
      case (st_ff)
         scsm_pkg::ST_IDLE:
         begin
            nxt_cnt = 8'h00;
            if (start)
            begin
               nxt_st  = scsm_pkg::ST_SHIFT;
               nxt_pat = pat_req;
            end
         end
         scsm_pkg::ST_SHIFT:
         begin
            if (st_clk_ff)
            begin
               nxt_cnt = cnt_ff + 8'h01;
               if (cnt_last(cnt_ff, scsm_pkg::SHIFT_LEN))
               begin
                  nxt_st  = scsm_pkg::ST_PRE;
                  nxt_cnt = 8'h00;
               end
            end
         end
         scsm_pkg::ST_PRE:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_last(cnt_ff, scsm_pkg::DEAD_CYC))
            begin
               nxt_st  = scsm_pkg::ST_CAP;
               nxt_cnt = 8'h00;
            end
         end
         scsm_pkg::ST_CAP:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_last(cnt_ff, scsm_pkg::CAP_CYC))
            begin
               nxt_st  = scsm_pkg::ST_POST;
               nxt_cnt = 8'h00;
               nxt_pat = pat_ff - 8'h01;
            end
         end
         scsm_pkg::ST_POST:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_last(cnt_ff, scsm_pkg::DEAD_CYC))
            begin
               nxt_cnt = 8'h00;
               nxt_st  = (pat_ff == 8'h00) ? scsm_pkg::ST_IDLE : scsm_pkg::ST_SHIFT;
            end
         end
         default:
         begin
            nxt_st  = scsm_pkg::ST_IDLE;
            nxt_cnt = 8'h00;
         end
      endcase
   end

   wire nxt_shift = (nxt_st == scsm_pkg::ST_SHIFT);
   // low from the dead cycles before capture until capture ends
   wire nxt_se    = ~((nxt_st == scsm_pkg::ST_PRE) | (nxt_st == scsm_pkg::ST_CAP));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_ff      <= scsm_pkg::ST_IDLE;
         cnt_ff     <= 8'h00;
         pat_ff     <= 8'h00;
         st_clk_ff  <= 1'b0;
         scan_en_ff <= 1'b1;
         cap_en_ff  <= 1'b0;
      end
      else
      begin
         st_ff      <= nxt_st;
         cnt_ff     <= nxt_cnt;
         pat_ff     <= nxt_pat;
         // clock only toggles in shift, parked low on every other state
         st_clk_ff  <= nxt_shift & (st_ff == scsm_pkg::ST_SHIFT) & ~st_clk_ff;
         scan_en_ff <= nxt_se;
         cap_en_ff  <= (nxt_st == scsm_pkg::ST_CAP);
      end
   end

   wire st_clk_en = (st_ff == scsm_pkg::ST_SHIFT);

   // clock controller inputs, steered by the single mode select
   assign lnk.cc_scan_en      = mode_ff ? ~cap_en_ff : atpg_scan_en;
   assign lnk.cc_shift_clk    = mode_ff ? st_clk_ff : cmp_clk_in;
   assign lnk.cc_shift_clk_en = mode_ff ? st_clk_en : atpg_shift_clk_en;

   // compression controls never pass through the sequencer
   assign cmp_update = cmp_update_in;
   assign cmp_bypass = cmp_bypass_in;
   assign cmp_lowpow = cmp_lowpow_in;

   assign sig_clk    = st_clk_ff & st_clk_en;
   assign cmp_clk    = mode_ff ? sig_clk : cmp_clk_in;

   // capture pulses always come back from the clock controller
   assign chain_clk  = mode_ff ? (scan_en_ff ? st_clk_ff : lnk.cc_clkout)
                               : (atpg_scan_en ? top_shift_clk : lnk.cc_clkout);

   assign st_scan_en = scan_en_ff;
   assign st_mode    = mode_ff;
   assign st_busy    = ~idle;

endmodule : scsm_dev

// ---- core/scsm_ctl.sv ----
// far end: user clock controller and apb-driven tap strobe generator
`timescale 1ns/10ps
module scsm_ctl
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   output wire logic        tap_busy,
   scsm_if.ctl              lnk
);

   logic [31:0]                 cmd_ff;
   logic [31:0]                 wdata_ff;
   logic [31:0]                 rdata_ff;
   logic [3:0]                  ccfg_ff;
   scsm_pkg::scsm_tap_st_t      ts_ff;
   logic [5:0]                  left_ff;
   logic                        tck_ff;
   logic [3:0]                  cap_left_ff;
   logic                        cap_clk_ff;
   logic                        gate_clk_ff;

   wire acc     = psel & penable;
   wire hit     = (paddr == scsm_pkg::A_CMD) | (paddr == scsm_pkg::A_WDATA) |
                  (paddr == scsm_pkg::A_RDATA) | (paddr == scsm_pkg::A_STAT) |
                  (paddr == scsm_pkg::A_CCFG);
   wire wr_cmd  = acc & pwrite & (paddr == scsm_pkg::A_CMD);
   wire idle    = (ts_ff == scsm_pkg::TS_IDLE);
   wire go      = wr_cmd & idle & pwdata[scsm_pkg::CMD_START];
   wire [5:0] len_req = pwdata[scsm_pkg::CMD_LEN_LSB +: scsm_pkg::CMD_LEN_W];
   // strobes change while tck is low, so the device sees them stable
   wire fall    = tck_ff;
   wire step    = ~idle & fall;

   assign pready   = 1'b1;
   assign pslverr  = acc & ~hit;
   assign tap_busy = ~idle;

   always_comb
   begin
      prdata = 32'h0000_0000;
      case (paddr)
         scsm_pkg::A_CMD:   prdata = cmd_ff;
         scsm_pkg::A_WDATA: prdata = wdata_ff;
         scsm_pkg::A_RDATA: prdata = rdata_ff;
         scsm_pkg::A_STAT:  prdata = {31'h0000_0000, ~idle};
         scsm_pkg::A_CCFG:  prdata = {28'h000_0000, ccfg_ff};
         default:           prdata = 32'h0000_0000;
      endcase
   end

   // writes while a sequence runs would corrupt the strobe order, so ignored
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_ff   <= scsm_pkg::CMD_RST;
         wdata_ff <= 32'h0000_0000;
         ccfg_ff  <= scsm_pkg::CCFG_RST;
      end
      else if (acc && pwrite && idle)
      begin
         if (paddr == scsm_pkg::A_CMD)
            cmd_ff <= {pwdata[31:9], 1'b0, pwdata[7:0]};
         if (paddr == scsm_pkg::A_WDATA)
            wdata_ff <= pwdata;
         if (paddr == scsm_pkg::A_CCFG)
            ccfg_ff <= pwdata[3:0];
      end
   end

   // tap sequence: capture, len shifts lsb first, update; tck is clk / 2
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ts_ff    <= scsm_pkg::TS_IDLE;
         left_ff  <= 6'h00;
         tck_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         tck_ff <= ~idle & ~tck_ff;
         if (go)
         begin
            ts_ff   <= scsm_pkg::TS_CAP;
            left_ff <= len_req;
         end
         else if (step)
         begin
            case (ts_ff)
               scsm_pkg::TS_CAP:
                  ts_ff <= (left_ff == 6'h00) ? scsm_pkg::TS_UPD : scsm_pkg::TS_SHIFT;
               scsm_pkg::TS_SHIFT:
               begin
                  rdata_ff <= {lnk.tap_so, rdata_ff[31:1]};
                  left_ff  <= left_ff - 6'h01;
                  if (left_ff == 6'h01)
                     ts_ff <= scsm_pkg::TS_UPD;
               end
               scsm_pkg::TS_UPD:
                  ts_ff <= scsm_pkg::TS_IDLE;
               default:
                  ts_ff <= scsm_pkg::TS_IDLE;
            endcase
         end
      end
   end

   wire [5:0] bit_idx = cmd_ff[scsm_pkg::CMD_LEN_LSB +: scsm_pkg::CMD_LEN_W] - left_ff;

   assign lnk.tck       = tck_ff;
   assign lnk.cap_dr    = (ts_ff == scsm_pkg::TS_CAP);
   assign lnk.sh_dr     = (ts_ff == scsm_pkg::TS_SHIFT);
   assign lnk.upd_dr    = (ts_ff == scsm_pkg::TS_UPD);
   assign lnk.tap_si    = wdata_ff[bit_idx[4:0]];
   assign lnk.tlr       = cmd_ff[scsm_pkg::CMD_TLR];
   assign lnk.instr_dec = cmd_ff[scsm_pkg::CMD_DEC];

   // user clock controller: shift clock when scan-enable high, own capture clock when low
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cap_left_ff <= 4'h0;
         cap_clk_ff  <= 1'b0;
         gate_clk_ff <= 1'b0;
      end
      else
      begin
         gate_clk_ff <= lnk.cc_shift_clk_en & ~gate_clk_ff;
         if (lnk.cc_scan_en)
         begin
            cap_left_ff <= ccfg_ff;
            cap_clk_ff  <= 1'b0;
         end
         else if (cap_left_ff != 4'h0)
         begin
            cap_clk_ff <= ~cap_clk_ff;
            if (cap_clk_ff)
               cap_left_ff <= cap_left_ff - 4'h1;
         end
      end
   end

   wire sh_src = cmd_ff[scsm_pkg::CMD_GATED] ? gate_clk_ff : lnk.cc_shift_clk;
   assign lnk.cc_clkout = lnk.cc_scan_en ? sh_src : cap_clk_ff;

endmodule : scsm_ctl

// ---- tb/scsm_sva.sv ----
// concurrent checks on the steering device and its link to the far end
`timescale 1ns/10ps
module scsm_sva
(
   input logic clk,
   input logic rst,
   input logic st_mode,
   input logic st_busy,
   input logic st_scan_en,
   input logic atpg_scan_en,
   input logic atpg_shift_clk_en,
   input logic cmp_clk_in,
   input logic top_shift_clk,
   input logic cmp_update_in,
   input logic cmp_update,
   input logic cmp_clk,
   input logic chain_clk,
   input logic sig_clk,
   input logic cc_scan_en,
   input logic cc_shift_clk,
   input logic cc_shift_clk_en,
   input logic cc_clkout
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_se_cmp;
      !st_mode |-> cc_scan_en == atpg_scan_en;
   endproperty
   a_se_cmp: assert property (p_se_cmp) else $error("scan enable mux wrong");
   property p_sclk_cmp;
      !st_mode |-> cc_shift_clk == cmp_clk_in;
   endproperty
   a_sclk_cmp: assert property (p_sclk_cmp) else $error("shift clock mux wrong");
   property p_en_cmp;
      !st_mode |-> cc_shift_clk_en == atpg_shift_clk_en;
   endproperty
   a_en_cmp: assert property (p_en_cmp) else $error("shift enable mux wrong");
   property p_upd;
      cmp_update == cmp_update_in;
   endproperty
   a_upd: assert property (p_upd) else $error("update not direct");
   property p_cmp_clk;
      st_mode ? (cmp_clk == sig_clk) : (cmp_clk == cmp_clk_in);
   endproperty
   a_cmp_clk: assert property (p_cmp_clk) else $error("block clock select wrong");
   property p_chain_cmp;
      !st_mode && atpg_scan_en |-> chain_clk == top_shift_clk;
   endproperty
   a_chain_cmp: assert property (p_chain_cmp) else $error("chains not on top clock");
   property p_sig_quiet;
      st_mode && !st_scan_en |-> !sig_clk;
   endproperty
   a_sig_quiet: assert property (p_sig_quiet) else $error("signature clock pulsed");
   property p_chain_cap;
      st_mode && !st_scan_en |-> chain_clk == cc_clkout;
   endproperty
   a_chain_cap: assert property (p_chain_cap) else $error("capture clock not passed");
   property p_cap_len;
      st_mode && $fell(cc_scan_en) |-> !cc_scan_en [*4] ##1 cc_scan_en;
   endproperty
   a_cap_len: assert property (p_cap_len) else $error("capture window length wrong");
   property p_cap_se;
      st_mode && !cc_scan_en |-> !st_scan_en;
   endproperty
   a_cap_se: assert property (p_cap_se) else $error("scan enable high in capture");
   property p_idle_se;
      !st_busy |-> st_scan_en;
   endproperty
   a_idle_se: assert property (p_idle_se) else $error("scan enable low while idle");
   property p_mode_hold;
      st_busy |=> $stable(st_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy");
endmodule : scsm_sva

// ---- tb/scsm_tb_top.sv ----
// self-checking bench: both ends joined, apb driven, device pins exercised
`timescale 1ns/10ps
module scsm_tb_top;
   logic        clk, rst, cmp_clk_in, top_shift_clk, atpg_scan_en, atpg_shift_clk_en;
   logic        cmp_update_in, cmp_bypass_in, cmp_lowpow_in, cmp_update, cmp_bypass;
   logic        cmp_lowpow, cmp_clk, chain_clk, sig_clk, st_scan_en, st_mode, st_busy;
   logic        psel, penable, pwrite, pready, pslverr, tap_busy, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_fail, n_checks, n_cap;

   scsm_if scsm_if_i ();
   scsm_dev scsm_dev_i (.clk, .rst, .cmp_clk_in, .top_shift_clk, .atpg_scan_en,
      .atpg_shift_clk_en, .cmp_update_in, .cmp_bypass_in, .cmp_lowpow_in, .cmp_update,
      .cmp_bypass, .cmp_lowpow, .cmp_clk, .chain_clk, .sig_clk, .st_scan_en, .st_mode,
      .st_busy, .lnk(scsm_if_i));
   scsm_ctl scsm_ctl_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tap_busy, .lnk(scsm_if_i));
   scsm_sva scsm_sva_i (.clk, .rst, .st_mode, .st_busy, .st_scan_en, .atpg_scan_en,
      .atpg_shift_clk_en, .cmp_clk_in, .top_shift_clk, .cmp_update_in, .cmp_update,
      .cmp_clk, .chain_clk, .sig_clk, .cc_scan_en(scsm_if_i.cc_scan_en),
      .cc_shift_clk(scsm_if_i.cc_shift_clk), .cc_shift_clk_en(scsm_if_i.cc_shift_clk_en),
      .cc_clkout(scsm_if_i.cc_clkout));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic finish_test;
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   // one idle edge after each transfer keeps psel from being driven twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // ends with the shifted-out word in rd
   task automatic scan(input logic [5:0] len, input logic [31:0] d, input logic t);
      apb(1'b1, scsm_pkg::A_WDATA, d);
      apb(1'b1, scsm_pkg::A_CMD, (32'h1 << scsm_pkg::CMD_START) |
          (32'(t) << scsm_pkg::CMD_TLR) | (32'h1 << scsm_pkg::CMD_DEC) | 32'(len));
      do
      begin
         apb(1'b0, scsm_pkg::A_STAT, 32'h0);
      end
      while (rd[0] !== 1'b0);
      apb(1'b0, scsm_pkg::A_RDATA, 32'h0);
   endtask : scan

   task automatic wait_for(input int sel, input logic v);
      while ((sel == 0 ? st_busy : sel == 1 ? scsm_if_i.cc_scan_en : st_mode) !== v)
      begin
         @(posedge clk);
      end
   endtask : wait_for

   initial
   begin
      {rst, psel, penable, pwrite} = 4'h8;
      paddr = 8'h00;
      pwdata = 32'h0;
      {cmp_clk_in, top_shift_clk, atpg_scan_en, atpg_shift_clk_en} = 4'h0;
      {cmp_update_in, cmp_bypass_in, cmp_lowpow_in} = 3'h0;
      n_fail = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, scsm_pkg::A_CMD, 32'h0);
      chk("cmd_rst", scsm_pkg::CMD_RST, rd);
      apb(1'b0, scsm_pkg::A_CCFG, 32'h0);
      chk("ccfg_rst", 32'(scsm_pkg::CCFG_RST), rd);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped_err", 32'h1, 32'(er));
      for (int i = 0; i < 16; i++)
      begin
         {atpg_scan_en, atpg_shift_clk_en, cmp_clk_in, top_shift_clk} <= 4'(i);
         {cmp_update_in, cmp_bypass_in, cmp_lowpow_in} <= 3'(i);
         @(posedge clk);
         chk("cc_scan_en", 32'(i[3]), 32'(scsm_if_i.cc_scan_en));
         chk("cc_shift_clk", 32'(i[1]), 32'(scsm_if_i.cc_shift_clk));
         chk("cc_shift_clk_en", 32'(i[2]), 32'(scsm_if_i.cc_shift_clk_en));
         chk("cmp_ctl", 32'(i[2:0]), 32'({cmp_update, cmp_bypass, cmp_lowpow}));
         chk("cmp_clk", 32'(i[1]), 32'(cmp_clk));
         if (i[3])
         begin
            chk("chain_clk", 32'(i[0]), 32'(chain_clk));
            chk("cc_clkout", 32'(i[1]), 32'(scsm_if_i.cc_clkout));
         end
      end
      // gated build: shift clock made from the enable, toggling each cycle
      apb(1'b1, scsm_pkg::A_CMD, 32'h1 << scsm_pkg::CMD_GATED);
      rd[0] = scsm_if_i.cc_clkout;
      @(posedge clk);
      chk("gated_clk", 32'(rd[0] === 1'b0), 32'(scsm_if_i.cc_clkout));
      {atpg_scan_en, atpg_shift_clk_en, cmp_clk_in, top_shift_clk} <= 4'h0;
      // open the insertion bit, then load mode, run and one pattern
      scan(6'd2, 32'h0000_0002, 1'b0);
      scan(6'd18, 32'h0000_040e, 1'b0);
      wait_for(0, 1'b1);
      chk("cc_scan_en_st", 32'h1, 32'(scsm_if_i.cc_scan_en));
      // mode clear while running must be ignored
      scan(6'd18, 32'h0000_0402, 1'b0);
      wait_for(1, 1'b0);
      chk("st_scan_en_cap", 32'h0, 32'(st_scan_en));
      n_cap = 0;
      while (scsm_if_i.cc_scan_en === 1'b0)
      begin
         if (scsm_if_i.cc_clkout === 1'b1)
            n_cap++;
         @(posedge clk);
      end
      chk("cap_pulses", 32'(scsm_pkg::CCFG_RST), 32'(n_cap));
      wait_for(0, 1'b0);
      chk("st_mode_kept", 32'h1, 32'(st_mode));
      // readback: dr, open bit, then the extra pipeline bit first out
      scan(6'd18, 32'h0000_0002, 1'b0);
      chk("status_scan", 32'h0005_8000, rd & 32'hffff_c000);
      wait_for(2, 1'b0);
      chk("st_mode_back", 32'h0, 32'(st_mode));
      // test-logic-reset closes the insertion bit and clears the pipe
      scan(6'd2, 32'h0000_0000, 1'b1);
      scan(6'd2, 32'h0000_0000, 1'b0);
      chk("tlr_closed", 32'h0, rd & 32'hc000_0000);
      finish_test;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      finish_test;
   end
endmodule : scsm_tb_top
